// ===== bench/ccu_pin_model.sv
module ccu_pin_model (
  // Unit drive and outside source
  input wire ccu_pkg::ccu_pin_drive_t drive,
  input wire logic ext_level,
  // Resolved pad level
  output logic pad
);
  timeunit 1ns;
  timeprecision 1ns;
  // The unit wins while it drives, so a port write can reach the capture logic
  assign pad = drive.oe ? drive.o : ext_level;
endmodule

// ===== bench/ccu_unit_sva.sv
module ccu_unit_sva #(
  parameter logic IS_SECOND = 1'b0
) (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Unit status
  input wire logic unit_event_flag,
  input wire logic pwm_mode,
  input wire logic [9:0] duty_value,
  input wire ccu_pkg::ccu_timebase_t time_base,
  input wire ccu_pkg::ccu_event_t special_event
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic wr;
  logic ev;

  // =========================================
  // Helpers: a committed write and any timer reset pulse
  assign wr = psel && penable && pwrite && pstrb[0];
  assign ev = special_event.first_timer_reset || special_event.third_timer_reset;

  // =========================================
  // Bus answers
  unmapped_err_a: assert property (psel && penable && paddr > 8'h10 |-> pslverr && prdata == 0)
    else $error("Unmapped access not refused");
  mapped_ok_a: assert property (psel && penable && paddr <= 8'h10 && paddr[1:0] == 2'b00 |-> pready && !pslverr)
    else $error("Mapped access refused");
  // Register effects seen through status outputs
  duty_bits_a: assert property (wr && paddr == 8'h00 |=> duty_value[1:0] == $past(pwdata[5:4]))
    else $error("Duty low bits not taken");
  data_low_a: assert property (wr && paddr == 8'h04 |=> duty_value[9:2] == $past(pwdata[7:0]))
    else $error("Data low byte not taken");
  pwm_decode_a: assert property (wr && paddr == 8'h00 |=> pwm_mode == ($past(pwdata[3:2]) == 2'b11))
    else $error("PWM decode wrong");
  pwm_timer_a: assert property ((time_base == ccu_pkg::CCU_TB_SECOND) == pwm_mode)
    else $error("PWM time base wrong");
  // Only software may lower the flag
  flag_sw_a: assert property ($fell(unit_event_flag) |-> $past(wr && ((paddr == 8'h10 && pwdata[0]) || (paddr == 8'h00 && pwdata[3:0] == 4'h0))))
    else $error("Flag cleared by hardware");
  // Special event pulses
  event_pulse_a: assert property (ev |=> !ev)
    else $error("Special event longer than one cycle");
  converter_a: assert property (special_event.converter_start == (IS_SECOND && ev))
    else $error("Converter start wrong");
  event_base_a: assert property (special_event.third_timer_reset |-> $past(time_base) == ccu_pkg::CCU_TB_THIRD)
    else $error("Reset sent to wrong timer");

  cover property ($rose(unit_event_flag));
  cover property (special_event.third_timer_reset);
  cover property (pwm_mode);
endmodule

bind ccu_unit ccu_unit_sva #(.IS_SECOND(IS_SECOND)) sva_u (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .unit_event_flag(unit_event_flag), .pwm_mode(pwm_mode),
  .duty_value(duty_value), .time_base(time_base), .special_event(special_event)
);

// ===== bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_CTL = ccu_pkg::OFS_CONTROL;
  localparam logic [7:0] A_LO = ccu_pkg::OFS_DATA_LOW;
  localparam logic [7:0] A_HI = ccu_pkg::OFS_DATA_HIGH;
  localparam logic [7:0] A_CFG = ccu_pkg::OFS_CONFIG;
  localparam logic [7:0] A_ST = ccu_pkg::OFS_STATUS;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] first_timer = 16'h0000;
  logic [15:0] third_timer = 16'h0000;
  logic def_ext = 1'b0;
  logic def_latch = 1'b0;
  logic def_dir = 1'b1;
  logic alt_dir = 1'b1;
  logic def_pad;
  logic alt_pad;
  ccu_pkg::ccu_pin_drive_t default_pin;
  ccu_pkg::ccu_pin_drive_t alternate_pin;
  logic unit_event_flag;
  logic pwm_mode;
  logic [9:0] duty_value;
  ccu_pkg::ccu_timebase_t time_base;
  ccu_pkg::ccu_event_t special_event;
  logic [31:0] rd_val;
  logic rd_err;
  int failures = 0;
  int compares = 0;
  int conv_cnt = 0;
  logic [3:0] modes [6] = '{4'h1, 4'h3, 4'hc, 4'hd, 4'he, 4'hf};
  logic [3:0] cmp_mode [4] = '{4'h2, 4'h8, 4'h9, 4'ha};
  logic [1:0] cmp_pin [4] = '{2'b01, 2'b01, 2'b10, 2'b11};

  // =========================================
  // Clock, design and pin partners
  always #50 clk = ~clk;
  ccu_unit #(.IS_SECOND(1'b1), .TIMER_W(16)) dut_u (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_timer(first_timer), .third_timer(third_timer),
    .default_pin_in(def_pad), .default_port_latch(def_latch),
    .default_pin_direction_bit(def_dir), .default_pin(default_pin),
    .alternate_pin_in(alt_pad), .alternate_port_latch(1'b0),
    .alternate_pin_direction_bit(alt_dir), .alternate_pin(alternate_pin),
    .unit_event_flag(unit_event_flag), .pwm_mode(pwm_mode), .duty_value(duty_value),
    .time_base(time_base), .special_event(special_event)
  );
  ccu_pin_model def_u (.drive(default_pin), .ext_level(def_ext), .pad(def_pad));
  ccu_pin_model alt_u (.drive(alternate_pin), .ext_level(1'b0), .pad(alt_pad));

  // Chip side: special events clear the timers and start the converter
  always @(posedge clk) begin
    if (special_event.first_timer_reset) first_timer <= 16'h0000;
    if (special_event.third_timer_reset) third_timer <= 16'h0000;
    if (special_event.converter_start) conv_cnt <= conv_cnt + 1;
  end

  // =========================================
  // Tasks
  task automatic tally_and_finish();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; a leading edge keeps back-to-back calls from double driving
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      tally_and_finish();
    end
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd_val, exp);
  endtask
  // Pin edges; latency through the synchroniser is about two clocks
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge clk);
      def_ext <= 1'b1;
      def_latch <= 1'b1;
      repeat (6) @(posedge clk);
      def_ext <= 1'b0;
      def_latch <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  // Restart a prescaler mode from off, then clear the flag
  task automatic fresh(input logic [31:0] m);
    wr(A_CTL, 32'h0);
    wr(A_CTL, m);
    wr(A_ST, 32'h1);
  endtask

  // =========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rdc("control", A_CTL, 32'h0);
    rdc("data_low", A_LO, 32'h0);
    rdc("data_high", A_HI, 32'h0);
    rdc("config", A_CFG, 32'h4);
    rdc("status", A_ST, 32'h0);
    rdc("unmapped", 8'h14, 32'h0);
    chk("unmapped_err", 32'(rd_err), 32'h1);
    // Two rising captures with no read between: the second overwrites
    wr(A_CTL, 32'h5);
    first_timer <= 16'h1234;
    edges(1);
    first_timer <= 16'h5678;
    edges(1);
    rdc("cap_low", A_LO, 32'h78);
    rdc("cap_high", A_HI, 32'h56);
    rdc("flag_held", A_ST, 32'h1);
    wr(A_ST, 32'h1);
    rdc("flag_clear", A_ST, 32'h0);
    // Falling edge only, on the third timer
    wr(A_CFG, 32'h6);
    wr(A_CTL, 32'h4);
    third_timer <= 16'hbeef;
    @(posedge clk);
    chk("base_1x", 32'(time_base), 32'(ccu_pkg::CCU_TB_THIRD));
    def_ext <= 1'b1;
    repeat (8) @(posedge clk);
    rdc("no_rise_cap", A_HI, 32'h56);
    def_ext <= 1'b0;
    repeat (8) @(posedge clk);
    rdc("fall_cap", A_HI, 32'hbe);
    wr(A_CFG, 32'h4);
    @(posedge clk);
    chk("base_00", 32'(time_base), 32'(ccu_pkg::CCU_TB_FIRST));
    // Prescalers with the pin as output: port writes make the edges
    def_dir <= 1'b0;
    fresh(32'h6);
    chk("pin_oe", 32'(default_pin.oe), 32'h1);
    edges(3);
    rdc("pre4_three", A_ST, 32'h0);
    edges(1);
    rdc("pre4_four", A_ST, 32'h1);
    fresh(32'h6);
    edges(2);
    fresh(32'h6);
    edges(3);
    rdc("pre_cleared", A_ST, 32'h0);
    fresh(32'h6);
    edges(2);
    wr(A_CTL, 32'h7);
    wr(A_ST, 32'h1);
    edges(13);
    rdc("pre16_kept", A_ST, 32'h0);
    edges(1);
    rdc("pre16_fire", A_ST, 32'h1);
    // Compare actions on the pin, data 0x00c8
    wr(A_LO, 32'hc8);
    wr(A_HI, 32'h0);
    first_timer <= 16'h0010;
    def_latch <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      fresh(32'(cmp_mode[i]));
      repeat (2) @(posedge clk);
      chk("cmp_init", 32'(default_pin.o), 32'(cmp_pin[i][1]));
      first_timer <= 16'h00c8;
      @(posedge clk);
      first_timer <= 16'h0010;
      repeat (4) @(posedge clk);
      chk("cmp_after", 32'(default_pin.o), 32'(cmp_pin[i][0]));
      rdc("cmp_flag", A_ST, {30'h0, cmp_pin[i][0], 1'b1});
    end
    // Special event on the third timer, second unit starts the converter
    wr(A_CFG, 32'h5);
    @(posedge clk);
    chk("base_01", 32'(time_base), 32'(ccu_pkg::CCU_TB_THIRD));
    third_timer <= 16'h0010;
    fresh(32'hb);
    third_timer <= 16'h00c8;
    @(posedge clk);
    third_timer <= 16'h00c9;
    repeat (5) @(posedge clk);
    chk("timer_reset", 32'(third_timer), 32'h0);
    chk("converter", 32'(conv_cnt), 32'h1);
    rdc("event_flag", A_ST, 32'h3);
    // PWM and reserved codes with duty bits 2'b10
    wr(A_LO, 32'hab);
    foreach (modes[i]) begin
      wr(A_CTL, 32'h20 | 32'(modes[i]));
      rdc("ctl_back", A_CTL, 32'h20 | 32'(modes[i]));
      chk("pwm_mode", 32'(pwm_mode), 32'(modes[i][3:2] == 2'b11));
      chk("pwm_base", 32'(time_base == ccu_pkg::CCU_TB_SECOND), 32'(modes[i][3:2] == 2'b11));
    end
    chk("duty", 32'(duty_value), 32'h2ae);
    // Second unit moved to the alternate pin
    def_latch <= 1'b0;
    alt_dir <= 1'b0;
    wr(A_CTL, 32'h0);
    wr(A_CFG, 32'h0);
    wr(A_CTL, 32'h9);
    repeat (2) @(posedge clk);
    chk("alt_pin", 32'(alternate_pin.o), 32'h1);
    chk("def_pin", 32'(default_pin.o), 32'h0);
    // Reset in mid-run restores the defaults
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rdc("cfg_rst", A_CFG, 32'h4);
    rdc("ctl_rst", A_CTL, 32'h0);
    tally_and_finish();
  end
endmodule

// ===== rtl/ccu_pkg.sv
package ccu_pkg;

  // ==========================================================
  // Register map (byte addresses on the APB side)
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_DATA_LOW = 8'h04;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ==========================================================
  // Field positions
  localparam int MODE_LSB = 0;
  localparam int DUTY_LSB = 4;
  localparam int CFG_ASSIGN_LSB = 0;
  localparam int CFG_ALT_BIT = 2;
  localparam int STAT_FLAG_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [1:0] DUTY_RST = 2'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] ASSIGN_RST = 2'h0;
  localparam logic ALT_SEL_RST = 1'b1;

  // ==========================================================
  // Capture prescaler terminal counts
  localparam logic [3:0] PRE_EVERY_LAST = 4'h0;
  localparam logic [3:0] PRE_4TH_LAST = 4'h3;
  localparam logic [3:0] PRE_16TH_LAST = 4'hf;

  // ==========================================================
  // Mode select codes
  typedef enum logic [3:0] {
    CCU_MODE_OFF = 4'b0000,
    CCU_MODE_RSVD1 = 4'b0001,
    CCU_MODE_TOGGLE = 4'b0010,
    CCU_MODE_RSVD3 = 4'b0011,
    CCU_MODE_CAP_FALL = 4'b0100,
    CCU_MODE_CAP_RISE = 4'b0101,
    CCU_MODE_CAP_RISE4 = 4'b0110,
    CCU_MODE_CAP_RISE16 = 4'b0111,
    CCU_MODE_CMP_SET = 4'b1000,
    CCU_MODE_CMP_CLR = 4'b1001,
    CCU_MODE_CMP_SOFT = 4'b1010,
    CCU_MODE_CMP_EVENT = 4'b1011,
    CCU_MODE_PWM0 = 4'b1100,
    CCU_MODE_PWM1 = 4'b1101,
    CCU_MODE_PWM2 = 4'b1110,
    CCU_MODE_PWM3 = 4'b1111
  } ccu_mode_t;

  // Time base in use
  typedef enum logic [1:0] {
    CCU_TB_FIRST = 2'b00,
    CCU_TB_SECOND = 2'b01,
    CCU_TB_THIRD = 2'b10
  } ccu_timebase_t;

  // Pin drive toward the pad
  typedef struct packed {
    logic o;
    logic oe;
  } ccu_pin_drive_t;

  // One-cycle special event pulses
  typedef struct packed {
    logic first_timer_reset;
    logic third_timer_reset;
    logic converter_start;
  } ccu_event_t;

endpackage

// ===== rtl/ccu_prescaler.sv
module ccu_prescaler #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic clear,
  input wire logic tick,
  input wire logic [W-1:0] last,
  // Qualified event
  output logic fire
);

  logic [W-1:0] cnt;

  // A count above the new terminal fires on the next tick: keeps switching glitch-free
  assign fire = tick & ~clear & (cnt >= last);

  // Edge counter, held across prescaler changes, cleared by clear, by srst and after each fire
  always_ff @(posedge clk) begin
    if (srst || clear) begin
      cnt <= '0;
    end else if (fire) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= W'(cnt + 1'b1);
    end
  end

endmodule

// ===== rtl/ccu_sync.sv
module ccu_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Raw level and its synchronised view
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta;
  logic prev;

  // ==========================================================
  // Two-flop synchroniser; only level is looked at by the edge logic
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= 1'b0;
      level <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= din;
      level <= meta;
      prev <= level;
    end
  end

  // Edges from synchronised samples only
  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule

// ===== rtl/ccu_unit.sv
module ccu_unit #(
  parameter logic IS_SECOND = 1'b0,
  parameter int TIMER_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shared timers
  input wire logic [TIMER_W-1:0] first_timer,
  input wire logic [TIMER_W-1:0] third_timer,
  // Default pin
  input wire logic default_pin_in,
  input wire logic default_port_latch,
  input wire logic default_pin_direction_bit,
  output ccu_pkg::ccu_pin_drive_t default_pin,
  // Alternate pin
  input wire logic alternate_pin_in,
  input wire logic alternate_port_latch,
  input wire logic alternate_pin_direction_bit,
  output ccu_pkg::ccu_pin_drive_t alternate_pin,
  // Status toward the rest of the chip
  output logic unit_event_flag,
  output logic pwm_mode,
  output logic [9:0] duty_value,
  output ccu_pkg::ccu_timebase_t time_base,
  output ccu_pkg::ccu_event_t special_event
);

  // ==========================================================
  // Registers
  ccu_pkg::ccu_mode_t mode_select_field;
  ccu_pkg::ccu_mode_t prev_mode;
  logic [1:0] duty_low_bits;
  logic [7:0] unit_data_low;
  logic [7:0] unit_data_high;
  logic [1:0] timer_assignment_bits;
  logic alternate_pin_select;
  logic compare_latch;
  logic match_prev;

  // ==========================================================
  // Decoded mode
  logic is_capture;
  logic is_compare;
  logic drives_pin;
  logic mode_changed;
  logic [TIMER_W-1:0] tb_value;
  logic [15:0] unit_data_register;
  logic match_now;
  logic match_pulse;
  logic capture_fire;
  logic event_pulse;

  assign unit_data_register = {unit_data_high, unit_data_low};
  assign is_capture = (mode_select_field[3:2] == 2'b01);
  assign is_compare = (mode_select_field == ccu_pkg::CCU_MODE_TOGGLE) ||
                      (mode_select_field[3:2] == 2'b10);
  assign pwm_mode = (mode_select_field[3:2] == 2'b11);
  assign mode_changed = (mode_select_field != prev_mode);
  // Reserved codes fall through every decode and leave the unit idle
  assign drives_pin = (mode_select_field == ccu_pkg::CCU_MODE_TOGGLE) ||
                      (mode_select_field == ccu_pkg::CCU_MODE_CMP_SET) ||
                      (mode_select_field == ccu_pkg::CCU_MODE_CMP_CLR);

  // ==========================================================
  // Time base selection
  always_comb begin
    if (pwm_mode) begin
      time_base = ccu_pkg::CCU_TB_SECOND;
    end else if (timer_assignment_bits[1]) begin
      time_base = ccu_pkg::CCU_TB_THIRD;
    end else if (timer_assignment_bits[0] && IS_SECOND) begin
      time_base = ccu_pkg::CCU_TB_THIRD;
    end else begin
      time_base = ccu_pkg::CCU_TB_FIRST;
    end
  end

  // The timer must be clock-synchronous; an async counter here is not handled
  assign tb_value = (time_base == ccu_pkg::CCU_TB_THIRD) ? third_timer : first_timer;

  // ==========================================================
  // Pin routing and edge sensing
  logic use_alternate;
  logic sense_raw;
  logic sense_level;
  logic pin_rise;
  logic pin_fall;
  logic active_latch;

  assign use_alternate = IS_SECOND && !alternate_pin_select;
  // Read back the pad itself, so a port write on an output pin still counts
  assign sense_raw = use_alternate ? alternate_pin_in : default_pin_in;

  ccu_sync u_sync (
    .clk(clk),
    .srst(srst),
    .din(sense_raw),
    .level(sense_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ==========================================================
  // Capture prescaler
  logic pre_tick;
  logic [3:0] pre_last;

  always_comb begin
    pre_tick = 1'b0;
    pre_last = ccu_pkg::PRE_EVERY_LAST;
    case (mode_select_field)
      ccu_pkg::CCU_MODE_CAP_FALL: begin
        pre_tick = pin_fall;
      end
      ccu_pkg::CCU_MODE_CAP_RISE: begin
        pre_tick = pin_rise;
      end
      ccu_pkg::CCU_MODE_CAP_RISE4: begin
        pre_tick = pin_rise;
        pre_last = ccu_pkg::PRE_4TH_LAST;
      end
      ccu_pkg::CCU_MODE_CAP_RISE16: begin
        pre_tick = pin_rise;
        pre_last = ccu_pkg::PRE_16TH_LAST;
      end
      default: begin
        pre_tick = 1'b0;
        pre_last = ccu_pkg::PRE_EVERY_LAST;
      end
    endcase
  end

  // Clear only outside capture; a change between capture codes keeps the count
  ccu_prescaler #(
    .W(4)
  ) u_prescaler (
    .clk(clk),
    .srst(srst),
    .clear(!is_capture),
    .tick(pre_tick),
    .last(pre_last),
    .fire(capture_fire)
  );

  // ==========================================================
  // Compare match, one pulse per match episode
  assign match_now = is_compare && (unit_data_register == tb_value[15:0]);
  assign match_pulse = match_now && !match_prev;
  assign event_pulse = match_pulse && (mode_select_field == ccu_pkg::CCU_MODE_CMP_EVENT);

  always_ff @(posedge clk) begin
    if (srst || !is_compare) begin
      match_prev <= 1'b0;
    end else begin
      match_prev <= match_now;
    end
  end

  // Mode history for detecting entry into a compare mode
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_mode <= ccu_pkg::CCU_MODE_OFF;
    end else begin
      prev_mode <= mode_select_field;
    end
  end

  // ==========================================================
  // Compare output latch
  always_ff @(posedge clk) begin
    if (srst) begin
      compare_latch <= 1'b0;
    end else begin
      case (mode_select_field)
        ccu_pkg::CCU_MODE_OFF: begin
          compare_latch <= 1'b0;
        end
        ccu_pkg::CCU_MODE_TOGGLE: begin
          if (match_pulse) begin
            compare_latch <= ~compare_latch;
          end
        end
        ccu_pkg::CCU_MODE_CMP_SET: begin
          if (mode_changed) begin
            compare_latch <= 1'b0;
          end else if (match_pulse) begin
            compare_latch <= 1'b1;
          end
        end
        ccu_pkg::CCU_MODE_CMP_CLR: begin
          if (mode_changed) begin
            compare_latch <= 1'b1;
          end else if (match_pulse) begin
            compare_latch <= 1'b0;
          end
        end
        default: begin
          compare_latch <= compare_latch;
        end
      endcase
    end
  end

  // ==========================================================
  // Pad drive: the toggle, set and clear compare modes own the active pin, otherwise the port latch does
  assign active_latch = use_alternate ? alternate_port_latch : default_port_latch;

  always_comb begin
    default_pin.oe = ~default_pin_direction_bit;
    alternate_pin.oe = ~alternate_pin_direction_bit;
    default_pin.o = default_port_latch;
    alternate_pin.o = alternate_port_latch;
    if (use_alternate) begin
      alternate_pin.o = drives_pin ? compare_latch : active_latch;
    end else begin
      default_pin.o = drives_pin ? compare_latch : active_latch;
    end
  end

  // ==========================================================
  // Special event pulses, registered
  always_ff @(posedge clk) begin
    if (srst) begin
      special_event <= '0;
    end else begin
      special_event.first_timer_reset <= event_pulse &&
                                         (time_base == ccu_pkg::CCU_TB_FIRST);
      special_event.third_timer_reset <= event_pulse &&
                                         (time_base == ccu_pkg::CCU_TB_THIRD);
      special_event.converter_start <= event_pulse && IS_SECOND;
    end
  end

  // ==========================================================
  // APB decode
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic lane0;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign lane0 = pstrb[0];
  assign wr = access && pwrite && lane0;
  assign mapped = (paddr == ccu_pkg::OFS_CONTROL) || (paddr == ccu_pkg::OFS_DATA_LOW) ||
                  (paddr == ccu_pkg::OFS_DATA_HIGH) || (paddr == ccu_pkg::OFS_CONFIG) ||
                  (paddr == ccu_pkg::OFS_STATUS);
  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // Control register
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_select_field <= ccu_pkg::ccu_mode_t'(ccu_pkg::MODE_RST);
      duty_low_bits <= ccu_pkg::DUTY_RST;
    end else if (wr && (paddr == ccu_pkg::OFS_CONTROL)) begin
      mode_select_field <= ccu_pkg::ccu_mode_t'(pwdata[ccu_pkg::MODE_LSB +: 4]);
      duty_low_bits <= pwdata[ccu_pkg::DUTY_LSB +: 2];
    end
  end

  assign duty_value = {unit_data_low, duty_low_bits};

  // Data bytes; a capture in the same cycle beats a software write
  always_ff @(posedge clk) begin
    if (srst) begin
      unit_data_low <= ccu_pkg::DATA_RST;
      unit_data_high <= ccu_pkg::DATA_RST;
    end else if (capture_fire) begin
      unit_data_low <= tb_value[7:0];
      unit_data_high <= tb_value[15:8];
    end else if (wr && (paddr == ccu_pkg::OFS_DATA_LOW)) begin
      unit_data_low <= pwdata[7:0];
    end else if (wr && (paddr == ccu_pkg::OFS_DATA_HIGH)) begin
      unit_data_high <= pwdata[7:0];
    end
  end

  // Configuration: timer assignment and second-unit pin select
  always_ff @(posedge clk) begin
    if (srst) begin
      timer_assignment_bits <= ccu_pkg::ASSIGN_RST;
      alternate_pin_select <= ccu_pkg::ALT_SEL_RST;
    end else if (wr && (paddr == ccu_pkg::OFS_CONFIG)) begin
      timer_assignment_bits <= pwdata[ccu_pkg::CFG_ASSIGN_LSB +: 2];
      alternate_pin_select <= pwdata[ccu_pkg::CFG_ALT_BIT];
    end
  end

  // Event flag: write one to clear, a new event in the same cycle wins
  always_ff @(posedge clk) begin
    if (srst) begin
      unit_event_flag <= 1'b0;
    end else if (capture_fire || match_pulse) begin
      unit_event_flag <= 1'b1;
    end else if (wr && (paddr == ccu_pkg::OFS_STATUS) && pwdata[ccu_pkg::STAT_FLAG_BIT]) begin
      unit_event_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Read data, sampled in the setup cycle and held through the access
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= '0;
    end else if (setup) begin
      case (paddr)
        ccu_pkg::OFS_CONTROL: begin
          prdata <= {24'h000000, 2'b00, duty_low_bits, mode_select_field};
        end
        ccu_pkg::OFS_DATA_LOW: begin
          prdata <= {24'h000000, unit_data_low};
        end
        ccu_pkg::OFS_DATA_HIGH: begin
          prdata <= {24'h000000, unit_data_high};
        end
        ccu_pkg::OFS_CONFIG: begin
          prdata <= {29'h0, alternate_pin_select, timer_assignment_bits};
        end
        ccu_pkg::OFS_STATUS: begin
          prdata <= {30'h0, sense_level, unit_event_flag};
        end
        default: begin
          prdata <= '0;
        end
      endcase
    end
  end

endmodule
